// File: rtl/fsi_consts.vh
// constants for the fault status and interrupt block
`ifndef FSI_CONSTS_VH
`define FSI_CONSTS_VH
`define FSI_OFS_THRESHOLD_CONFIG       8'h09
`define FSI_OFS_LATCHED      8'h0C
`define FSI_OFS_EVENT        8'h0E
`define FSI_OFS_ENABLE       8'h0F
`define FSI_BIT_EV_TEMP      5
`define FSI_BIT_EV_SUPPLY    4
`define FSI_BIT_THERMAL_OFF  4
`define FSI_RST_EVENT        6'h00
`define FSI_RST_ENABLE       6'h00
`define FSI_RST_THRESHOLD_CONFIG       6'h00
`define FSI_SLAVE_ADDR       7'h48
`define FSI_SLAVE_ADDR_ALT   7'h49
`define FSI_GENERAL_CALL     7'h00
`define FSI_SUPPLY_STEPS     15
`define FSI_SUPPLY_SEL_MAX   4'hE
`define FSI_TEMP_SEL_MAX     2'h2
`define FSI_CLK_KHZ          20000
`define FSI_SCL_MAX_KHZ      400
`define FSI_PG_DELAY_NS      50000
`endif

// File: rtl/fsi_good_filter.v
// power-good deglitch filter for one channel
`timescale 1ns/1ps
`include "fsi_consts.vh"
module fsi_good_filter #(
  parameter DELAY_CYC = 1000,
  parameter CW        = 11
) (
  input  wire sys_clk,
  input  wire arst_n,
  input  wire raw_good,
  output reg  good_q
);
  reg [CW-1:0] cnt_q;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q  <= {CW{1'b0}};
      good_q <= 1'b0;
    end else if (raw_good) begin
      cnt_q  <= {CW{1'b0}};
      good_q <= 1'b1;
    end else if (cnt_q == DELAY_CYC[CW-1:0]) begin
      good_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
    end
  end
endmodule

// File: rtl/fsi_top.v
// fault status, alert and serial register port of the power device
`timescale 1ns/1ps
`include "fsi_consts.vh"
module fsi_top #(
  parameter ALT_ADDR = `FSI_SLAVE_ADDR_ALT
) (
  input  wire        sys_clk,
  input  wire        arst_n,
  input  wire        scl_in,
  input  wire        sda_in,
  output reg         sda_out_q,
  output reg         sda_oe_n_q,
  output reg         alert_out_q,
  output reg         alert_oe_n_q,
  input  wire        slave_addr_select,
  input  wire [3:0]  channel_enable_in,
  input  wire [3:0]  channel_output_good,
  input  wire [2:0]  temp_above_level,
  input  wire [14:0] first_channel_supply_low,
  input  wire        thermal_hot_in,
  output reg  [3:0]  channel_run_q,
  output reg  [3:0]  soft_start_q,
  output reg         thermal_off_q
);
  localparam NIN = 30;
  localparam PG_CYC = (`FSI_PG_DELAY_NS * `FSI_CLK_KHZ + 999999) / 1000000;
  localparam S_IDLE = 4'h0;
  localparam S_ADDR = 4'h1;
  localparam S_AACK = 4'h2;
  localparam S_SUB  = 4'h3;
  localparam S_SACK = 4'h4;
  localparam S_WDAT = 4'h5;
  localparam S_WACK = 4'h6;
  localparam S_RDAT = 4'h7;
  localparam S_RACK = 4'h8;

  // two-stage synchronisers for every pin input
  wire [NIN-1:0] raw_in = {scl_in, sda_in, slave_addr_select, channel_enable_in,
                           channel_output_good, temp_above_level,
                           first_channel_supply_low, thermal_hot_in};
  reg  [NIN-1:0] meta_q;
  reg  [NIN-1:0] sync_q;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      // serial lines idle high; a low reset value would fake an edge
      meta_q <= {2'b11, {(NIN-2){1'b0}}};
      sync_q <= {2'b11, {(NIN-2){1'b0}}};
    end else begin
      meta_q <= raw_in;
      sync_q <= meta_q;
    end
  end
  wire        scl_s     = sync_q[29];
  wire        sda_s     = sync_q[28];
  wire        asel_s    = sync_q[27];
  wire [3:0]  en_s      = sync_q[26:23];
  wire [3:0]  pg_raw_s  = sync_q[22:19];
  wire [2:0]  temp_s    = sync_q[18:16];
  wire [14:0] supply_s  = sync_q[15:1];
  wire        hot_s     = sync_q[0];

  reg scl_d1_q;
  reg sda_d1_q;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else begin
      scl_d1_q <= scl_s;
      sda_d1_q <= sda_s;
    end
  end
  wire scl_rise = scl_s & ~scl_d1_q;
  wire scl_fall = ~scl_s & scl_d1_q;
  wire bus_start = scl_s & scl_d1_q & sda_d1_q & ~sda_s;
  wire bus_stop  = scl_s & scl_d1_q & ~sda_d1_q & sda_s;

  wire [3:0] pg_good;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pg
      fsi_good_filter #(.DELAY_CYC(PG_CYC), .CW(11)) u_flt (
        .sys_clk  (sys_clk),
        .arst_n   (arst_n),
        .raw_good (pg_raw_s[gi]),
        .good_q   (pg_good[gi])
      );
    end
  endgenerate

  reg  [5:0] event_q;
  reg  [5:0] enable_q;
  reg  [5:0] threshold_config_q;
  reg        thermal_latched_q;
  reg  [3:0] pg_prev_q;
  reg        hot_prev_q;
  reg        wr_stb;
  reg  [7:0] wr_addr;
  reg  [7:0] wr_data;

  function [7:0] reg_read;
    input [7:0] a;
    begin
      case (a)
        `FSI_OFS_THRESHOLD_CONFIG:  reg_read = {2'h0, threshold_config_q};
        `FSI_OFS_LATCHED: reg_read = {3'h0, thermal_latched_q, 4'h0};
        `FSI_OFS_EVENT:   reg_read = {2'h0, event_q};
        `FSI_OFS_ENABLE:  reg_read = {2'h0, enable_q};
        default:          reg_read = 8'h00;
      endcase
    end
  endfunction

  // threshold select, clamped to valid settings
  wire [1:0] temp_sel = (threshold_config_q[5:4] > `FSI_TEMP_SEL_MAX) ? `FSI_TEMP_SEL_MAX
                                                             : threshold_config_q[5:4];
  wire [3:0] sup_sel  = (threshold_config_q[3:0] > `FSI_SUPPLY_SEL_MAX) ? `FSI_SUPPLY_SEL_MAX
                                                               : threshold_config_q[3:0];
  wire [5:0] ev_set;
  assign ev_set[`FSI_BIT_EV_TEMP]   = temp_s[temp_sel];
  assign ev_set[`FSI_BIT_EV_SUPPLY] = supply_s[sup_sel];
  assign ev_set[3:0]                = pg_prev_q & ~pg_good;

  wire       all_off = ~|en_s;
  wire [5:0] ev_wclr = (wr_stb && wr_addr == `FSI_OFS_EVENT) ? wr_data[5:0] : 6'h00;
  wire [5:0] event_d = (event_q & ~ev_wclr & ~{6{all_off}}) | ev_set;
  wire       lat_wclr = wr_stb && wr_addr == `FSI_OFS_LATCHED &&
                        wr_data[`FSI_BIT_THERMAL_OFF];
  wire       thermal_latched_d = (thermal_latched_q & ~lat_wclr) | hot_s;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      event_q           <= `FSI_RST_EVENT;
      enable_q          <= `FSI_RST_ENABLE;
      threshold_config_q          <= `FSI_RST_THRESHOLD_CONFIG;
      thermal_latched_q <= 1'b0;
      pg_prev_q         <= 4'h0;
      hot_prev_q        <= 1'b0;
      alert_out_q       <= 1'b0;
      alert_oe_n_q      <= 1'b1;
      channel_run_q     <= 4'h0;
      soft_start_q      <= 4'h0;
      thermal_off_q     <= 1'b0;
    end else begin
      event_q           <= event_d;
      thermal_latched_q <= thermal_latched_d;
      pg_prev_q         <= pg_good;
      hot_prev_q        <= hot_s;
      if (wr_stb && wr_addr == `FSI_OFS_ENABLE) begin
        enable_q <= wr_data[5:0];
      end
      if (wr_stb && wr_addr == `FSI_OFS_THRESHOLD_CONFIG) begin
        threshold_config_q <= wr_data[5:0];
      end
      alert_out_q <= 1'b0;
      alert_oe_n_q <= ~|(event_q & enable_q);
      thermal_off_q <= hot_s;
      channel_run_q <= hot_s ? 4'h0 : en_s;
      soft_start_q <= (hot_prev_q & ~hot_s) ? en_s : 4'h0;
    end
  end

  // oversampled serial clock
  // serial slave; 20 MHz sampling gives wide margin for the 400 kHz bus
  reg [3:0] state_q;
  reg [3:0] bitcnt_q;
  reg [7:0] shift_q;
  reg [7:0] tx_q;
  reg [7:0] ptr_q;
  reg       rw_q;
  reg       mack_q;
  wire [6:0] my_addr = asel_s ? ALT_ADDR[6:0] : `FSI_SLAVE_ADDR;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q    <= S_IDLE;
      bitcnt_q   <= 4'h0;
      shift_q    <= 8'h00;
      tx_q       <= 8'h00;
      ptr_q      <= 8'h00;
      rw_q       <= 1'b0;
      mack_q     <= 1'b1;
      sda_out_q  <= 1'b0;
      sda_oe_n_q <= 1'b1;
      wr_stb     <= 1'b0;
      wr_addr    <= 8'h00;
      wr_data    <= 8'h00;
    end else begin
      wr_stb    <= 1'b0;
      sda_out_q <= 1'b0;
      if (bus_stop) begin
        state_q    <= S_IDLE;
        sda_oe_n_q <= 1'b1;
      end else if (bus_start) begin
        // a repeated start stays with the master holding the bus
        state_q    <= S_ADDR;
        bitcnt_q   <= 4'h0;
        sda_oe_n_q <= 1'b1;
      end else if (scl_rise) begin
        case (state_q)
          S_ADDR, S_SUB, S_WDAT: begin
            shift_q  <= {shift_q[6:0], sda_s};
            bitcnt_q <= bitcnt_q + 4'h1;
          end
          S_RDAT: begin
            bitcnt_q <= bitcnt_q + 4'h1;
          end
          S_RACK: begin
            mack_q <= sda_s;
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (state_q)
          S_ADDR: begin
            if (bitcnt_q == 4'h8) begin
              if (shift_q[7:1] == my_addr && shift_q[7:1] != `FSI_GENERAL_CALL) begin
                rw_q       <= shift_q[0];
                sda_oe_n_q <= 1'b0;
                state_q    <= S_AACK;
              end else begin
                state_q <= S_IDLE;
              end
            end
          end
          S_AACK: begin
            bitcnt_q <= 4'h0;
            if (rw_q) begin
              tx_q       <= reg_read(ptr_q);
              sda_oe_n_q <= |(reg_read(ptr_q) & 8'h80);
              state_q    <= S_RDAT;
            end else begin
              sda_oe_n_q <= 1'b1;
              state_q    <= S_SUB;
            end
          end
          S_SUB: begin
            if (bitcnt_q == 4'h8) begin
              ptr_q      <= shift_q;
              sda_oe_n_q <= 1'b0;
              state_q    <= S_SACK;
            end
          end
          S_SACK, S_WACK: begin
            if (state_q == S_WACK) begin
              ptr_q <= ptr_q + 8'h01;
            end
            sda_oe_n_q <= 1'b1;
            bitcnt_q   <= 4'h0;
            state_q    <= S_WDAT;
          end
          S_WDAT: begin
            if (bitcnt_q == 4'h8) begin
              wr_stb     <= 1'b1;
              wr_addr    <= ptr_q;
              wr_data    <= shift_q;
              sda_oe_n_q <= 1'b0;
              state_q    <= S_WACK;
            end
          end
          S_RDAT: begin
            if (bitcnt_q == 4'h8) begin
              sda_oe_n_q <= 1'b1;
              state_q    <= S_RACK;
            end else begin
              tx_q       <= {tx_q[6:0], 1'b0};
              sda_oe_n_q <= tx_q[6];
            end
          end
          S_RACK: begin
            bitcnt_q <= 4'h0;
            // read held until master ends it
            if (!mack_q) begin
              tx_q       <= reg_read(ptr_q + 8'h01);
              sda_oe_n_q <= |(reg_read(ptr_q + 8'h01) & 8'h80);
              ptr_q      <= ptr_q + 8'h01;
              state_q    <= S_RDAT;
            end else begin
              sda_oe_n_q <= 1'b1;
              state_q    <= S_IDLE;
            end
          end
          default: begin
            sda_oe_n_q <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule

// File: rtl/unused_placeholder_removed.v
// empty

// File: verif/fsi_top_checker.sv
// concurrent checks on the fault, alert and serial port pins
`timescale 1ns/1ps
module fsi_top_checker (
  input wire       sys_clk,
  input wire       arst_n,
  input wire       scl_in,
  input wire       sda_out_q,
  input wire       sda_oe_n_q,
  input wire       alert_out_q,
  input wire       alert_oe_n_q,
  input wire [3:0] channel_enable_in,
  input wire       thermal_hot_in,
  input wire [3:0] channel_run_q,
  input wire [3:0] soft_start_q,
  input wire       thermal_off_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_alert_pull_low: assert property (!alert_oe_n_q |-> !alert_out_q)
    else $error("alert enabled but not low");
  a_sda_pull_low: assert property (!sda_oe_n_q |-> !sda_out_q)
    else $error("data line enabled but not low");
  // moves only while the clock is low, so the master samples a steady bit
  a_sda_move_low: assert property ($changed(sda_oe_n_q) |-> !scl_in)
    else $error("data line moved while clock high");
  a_run_follow_en: assert property
    ((channel_enable_in == 4'hF && !thermal_hot_in)[*6] |-> channel_run_q == 4'hF)
    else $error("channels not running");
  a_hot_stops_all: assert property
    (thermal_hot_in[*6] |-> thermal_off_q && channel_run_q == 4'h0)
    else $error("shutdown not taken");
  a_off_holds_run: assert property
    (thermal_off_q && $past(thermal_off_q) |-> channel_run_q == 4'h0)
    else $error("channel runs during shutdown");
  a_soft_after_off: assert property (soft_start_q != 4'h0 |->
    ($past(thermal_off_q) || $past(thermal_off_q, 2)) &&
    (soft_start_q & ~channel_enable_in) == 4'h0)
    else $error("soft start without shutdown end");
  a_soft_one_cycle: assert property
    (soft_start_q != 4'h0 |=> soft_start_q == 4'h0)
    else $error("soft start pulse too long");
  c_alert: cover property (!alert_oe_n_q);
  c_soft: cover property (soft_start_q != 4'h0);
  c_ack: cover property (!sda_oe_n_q && scl_in);
endmodule

bind fsi_top fsi_top_checker u_chk (.sys_clk, .arst_n, .scl_in, .sda_out_q, .sda_oe_n_q,
  .alert_out_q, .alert_oe_n_q, .channel_enable_in, .thermal_hot_in, .channel_run_q,
  .soft_start_q, .thermal_off_q);

// File: verif/fsi_i2c_master.sv
// serial bus master model facing the register port
`timescale 1ns/1ps
module fsi_i2c_master (
  output logic scl_o,
  output logic sda_o,
  input  wire  sda_i
);
  localparam Q = 100;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic bit_io(input logic b, output logic r);
    #Q sda_o = b;
    #Q scl_o = 1'b1;
    #Q r = sda_i;
    #Q scl_o = 1'b0;
  endtask
  // also serves as repeated start from a low clock
  task automatic start();
    #Q sda_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b0;
    #Q scl_o = 1'b0;
  endtask
  // stop ends the transfer, freeing the port
  task automatic stop();
    #Q sda_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b1;
    #Q;
  endtask
  task automatic xfer(input [7:0] d, input logic mk, output [7:0] q, output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(mk, r);
    ak = ~r;
  endtask
endmodule

// File: verif/fsi_top_tb.sv
// register level tests of the fault status and alert block
`timescale 1ns/1ps
module fsi_top_tb;
  logic        sys_clk, arst_n, sda_m, scl, sel, hot;
  logic [3:0]  en, good;
  logic [2:0]  temp;
  logic [14:0] sup;
  logic [7:0]  v;
  wire         sda_out_q, sda_oe_n_q, alert_out_q, alert_oe_n_q, thermal_off_q;
  wire  [3:0]  channel_run_q, soft_start_q;
  // open drain: pull-up unless someone pulls low
  wire         sda = sda_m & (sda_oe_n_q | sda_out_q);
  int          n_fail, total_checks, cyc, ks[3] = '{0, 7, 14};
  fsi_top dut (.sys_clk(sys_clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda),
    .sda_out_q(sda_out_q), .sda_oe_n_q(sda_oe_n_q), .alert_out_q(alert_out_q),
    .alert_oe_n_q(alert_oe_n_q), .slave_addr_select(sel), .channel_enable_in(en),
    .channel_output_good(good), .temp_above_level(temp), .first_channel_supply_low(sup),
    .thermal_hot_in(hot), .channel_run_q(channel_run_q), .soft_start_q(soft_start_q),
    .thermal_off_q(thermal_off_q));
  fsi_i2c_master m (.scl_o(scl), .sda_o(sda_m), .sda_i(sda));
  always #25 sys_clk = ~sys_clk;
  // whole run needs about 15000 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wr(input [7:0] a, input [7:0] d);
    logic [7:0] q;
    logic k;
    m.start();
    m.xfer(8'h90, 1'b1, q, k);
    m.xfer(a, 1'b1, q, k);
    m.xfer(d, 1'b1, q, k);
    m.stop();
  endtask
  task automatic rd_chk(input [7:0] a, input [7:0] exp);
    logic [7:0] q;
    logic k;
    m.start();
    m.xfer(8'h90, 1'b1, q, k);
    m.xfer(a, 1'b1, q, k);
    m.start();
    m.xfer(8'h91, 1'b1, q, k);
    m.xfer(8'hFF, 1'b1, q, k);
    m.stop();
    chk(q, exp);
  endtask
  task automatic ack_chk(input [7:0] b, input logic exp);
    logic [7:0] q;
    logic k;
    m.start();
    m.xfer(b, 1'b1, q, k);
    m.stop();
    chk({7'h00, k}, {7'h00, exp});
  endtask
  initial begin
    sys_clk = 1'b0; arst_n = 1'b0; sel = 1'b0; hot = 1'b0;
    en = 4'hF; good = 4'hF; temp = 3'h0; sup = 15'h0000;
    tick(3);
    arst_n = 1'b1;
    tick(4);
    rd_chk(8'h0F, 8'h00);
    rd_chk(8'h0E, 8'h00);
    rd_chk(8'h0C, 8'h00);
    rd_chk(8'h20, 8'h00);
    ack_chk(8'h92, 1'b0);
    ack_chk(8'h00, 1'b0);
    ack_chk(8'h90, 1'b1);
    wr(8'h0F, 8'h3F);
    rd_chk(8'h0F, 8'h3F);
    good = 4'hB;
    tick(500);
    good = 4'hF;
    tick(20);
    rd_chk(8'h0E, 8'h00);
    chk({7'h00, alert_oe_n_q}, 8'h01);
    good = 4'hB;
    tick(1100);
    rd_chk(8'h0E, 8'h04);
    chk({7'h00, alert_oe_n_q}, 8'h00);
    wr(8'h0E, 8'h00);
    rd_chk(8'h0E, 8'h04);
    wr(8'h0F, 8'h3B);
    chk({7'h00, alert_oe_n_q}, 8'h01);
    wr(8'h0F, 8'h3F);
    good = 4'hF;
    wr(8'h0E, 8'h04);
    rd_chk(8'h0E, 8'h00);
    chk({7'h00, alert_oe_n_q}, 8'h01);
    for (int s = 0; s < 3; s++) begin
      wr(8'h09, 8'(s << 4));
      temp = 3'((1 << s) - 1);
      tick(10);
      rd_chk(8'h0E, 8'h00);
      temp = 3'((2 << s) - 1);
      tick(10);
      rd_chk(8'h0E, 8'h20);
      chk({4'h0, channel_run_q}, 8'h0F);
      temp = 3'h0;
      wr(8'h0E, 8'h20);
    end
    foreach (ks[i]) begin
      wr(8'h09, 8'(ks[i]));
      sup = 15'h7FFF << (ks[i] + 1);
      tick(10);
      rd_chk(8'h0E, 8'h00);
      sup = 15'h7FFF << ks[i];
      tick(10);
      rd_chk(8'h0E, 8'h10);
      chk({4'h0, channel_run_q}, 8'h0F);
      sup = 15'h0000;
      wr(8'h0E, 8'h10);
    end
    temp = 3'h1;
    tick(10);
    temp = 3'h0;
    rd_chk(8'h0E, 8'h20);
    en = 4'h0;
    tick(10);
    en = 4'hF;
    tick(10);
    rd_chk(8'h0E, 8'h00);
    hot = 1'b1;
    tick(10);
    chk({4'h0, channel_run_q}, 8'h00);
    rd_chk(8'h0C, 8'h10);
    wr(8'h0C, 8'h10);
    rd_chk(8'h0C, 8'h10);
    @(negedge sys_clk) hot = 1'b0;
    for (int n = 0; n < 20 && soft_start_q === 4'h0; n++) @(negedge sys_clk);
    chk({4'h0, soft_start_q}, 8'h0F);
    tick(5);
    chk({4'h0, channel_run_q}, 8'h0F);
    wr(8'h0C, 8'h10);
    rd_chk(8'h0C, 8'h00);
    sel = 1'b1;
    tick(10);
    ack_chk(8'h92, 1'b1);
    ack_chk(8'h90, 1'b0);
    wrap_up();
  end
endmodule
